// >>> boime_exec.sv
// Execution unit for jump, or-literal, increment, or-register and move
module boime_exec
    import boime_pkg::*;
#(
    parameter int unsigned DATA_W = BOIME_DATA_W,
    parameter int unsigned PC_W = BOIME_PC_W,
    parameter int unsigned IMM_W = BOIME_IMM_W,
    parameter int unsigned ADDR_W = BOIME_ADDR_W
)
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    input wire boime_pkg::boime_instr_type i_instr,
    input wire logic [7:0] i_reg_rdata,
    input wire logic [7:0] i_pc_high_latch,
    output logic o_ready,
    output logic [12:0] o_pc,
    output logic [7:0] o_acc,
    output logic o_zero,
    output boime_pkg::boime_wr_type o_wr
);
    import boime_pkg::*;

    // Packed carriers fix every width; refuse values they cannot serve
    if (DATA_W != BOIME_DATA_W)
    begin : g_chk_data_w
        $error("data width must equal the carrier width");
    end
    if (IMM_W != BOIME_IMM_W)
    begin : g_chk_imm_w
        $error("immediate width must equal the carrier width");
    end
    // Two latch bits sit above the immediate in the pc
    if (PC_W != IMM_W + BOIME_LATCH_HI - BOIME_LATCH_LO + 1)
    begin : g_chk_pc_w
        $error("pc width must be the immediate plus two latch bits");
    end
    if (ADDR_W != BOIME_ADDR_W)
    begin : g_chk_addr_w
        $error("address width must equal the carrier width");
    end

    typedef enum logic [1:0]
    {
        BOIME_ST_RUN = 2'b01,
        BOIME_ST_JWAIT = 2'b10
    } boime_state_type;

    boime_state_type state_r, state_nxt;
    logic [12:0] pc_r, pc_nxt;
    logic [7:0] acc_r, acc_nxt;
    logic zero_r, zero_nxt;
    boime_wr_type wr_r, wr_nxt;
    logic ready_r, ready_nxt;
    logic [7:0] result;

    // Next state, data path and flag update
    always_comb
    begin
        state_nxt = state_r;
        pc_nxt = pc_r;
        acc_nxt = acc_r;
        zero_nxt = zero_r;
        wr_nxt = '0;
        ready_nxt = 1'b1;
        result = 8'h00;
        unique case (state_r)
            BOIME_ST_RUN:
            begin
                if (i_valid && ready_r) // Refused while not ready
                begin
                    unique case (i_instr.op)
                        BOIME_OP_JUMP:
                        begin
                            pc_nxt = {i_pc_high_latch[BOIME_LATCH_HI:
                                BOIME_LATCH_LO], i_instr.imm};
                            state_nxt = BOIME_ST_JWAIT;
                            ready_nxt = 1'b0;
                        end
                        BOIME_OP_ORLIT:
                        begin
                            result = acc_r | i_instr.imm[7:0];
                            acc_nxt = result;
                        end
                        BOIME_OP_INC, BOIME_OP_ORREG, BOIME_OP_MOVE:
                        begin
                            if (i_instr.op == BOIME_OP_INC)
                                result = i_reg_rdata + 8'h01;
                            else if (i_instr.op == BOIME_OP_ORREG)
                                result = acc_r | i_reg_rdata;
                            else
                                result = i_reg_rdata;
                            if (i_instr.dest)
                            begin
                                wr_nxt.we = 1'b1;
                                wr_nxt.addr = i_instr.addr;
                                wr_nxt.data = result;
                            end
                            else
                                acc_nxt = result;
                        end
                        default:
                        begin
                            result = 8'h00;
                        end
                    endcase
                    if (i_instr.op != BOIME_OP_JUMP &&
                        i_instr.op <= BOIME_OP_MOVE)
                        zero_nxt = (result == 8'h00);
                    if (i_instr.op != BOIME_OP_JUMP)
                        pc_nxt = pc_r + 13'h0001;
                end
            end
            BOIME_ST_JWAIT:
            begin
                state_nxt = BOIME_ST_RUN; // Second jump cycle
            end
            default:
            begin
                state_nxt = BOIME_ST_RUN;
            end
        endcase
    end

    // State registers
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            state_r <= BOIME_ST_RUN;
            pc_r <= BOIME_PC_RST;
            acc_r <= BOIME_ACC_RST;
            zero_r <= 1'b0;
            wr_r <= '0;
            ready_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            pc_r <= pc_nxt;
            acc_r <= acc_nxt;
            zero_r <= zero_nxt;
            wr_r <= wr_nxt;
            ready_r <= ready_nxt;
        end
    end

    assign o_ready = ready_r;
    assign o_pc = pc_r;
    assign o_acc = acc_r;
    assign o_zero = zero_r;
    assign o_wr = wr_r;

    // Checks run on the core clock and rest while reset is high
    default clocking cb_core @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    AST_JUMP_PC: assert property (
        (i_valid && o_ready && i_instr.op == BOIME_OP_JUMP)
        |=> o_pc[BOIME_IMM_W-1:0] == $past(i_instr.imm))
        else $error("jump low target wrong");
    AST_JUMP_HIGH: assert property (
        (i_valid && o_ready && i_instr.op == BOIME_OP_JUMP)
        |=> o_pc[BOIME_PC_W-1:BOIME_IMM_W]
        == $past(i_pc_high_latch[BOIME_LATCH_HI:BOIME_LATCH_LO]))
        else $error("jump high target wrong");
    AST_JUMP_TWO: assert property (
        (i_valid && o_ready && i_instr.op == BOIME_OP_JUMP)
        |=> !o_ready ##1 o_ready)
        else $error("jump not two cycles");
    AST_JUMP_FLAG: assert property (
        (i_valid && o_ready && i_instr.op == BOIME_OP_JUMP)
        |=> $stable(o_zero) && $stable(o_acc) && !o_wr.we)
        else $error("jump touched state");
    AST_BUBBLE: assert property (
        !o_ready |=> $stable(o_pc) && $stable(o_acc) && $stable(o_zero)
        && !o_wr.we)
        else $error("instruction taken while not ready");
    AST_ORLIT: assert property (
        (i_valid && o_ready && i_instr.op == BOIME_OP_ORLIT)
        |=> o_acc == ($past(o_acc) | $past(i_instr.imm[7:0])) && !o_wr.we)
        else $error("or literal wrong");
    AST_INC_REG: assert property (
        (i_valid && o_ready && i_instr.op == BOIME_OP_INC && i_instr.dest)
        |=> o_wr.we && o_wr.data == 8'($past(i_reg_rdata) + 8'h01)
        && o_wr.addr == $past(i_instr.addr) && $stable(o_acc))
        else $error("increment to register wrong");
    AST_INC_ACC: assert property (
        (i_valid && o_ready && i_instr.op == BOIME_OP_INC && !i_instr.dest)
        |=> !o_wr.we && o_acc == 8'($past(i_reg_rdata) + 8'h01))
        else $error("increment to acc wrong");
    AST_ORREG_ACC: assert property (
        (i_valid && o_ready && i_instr.op == BOIME_OP_ORREG && !i_instr.dest)
        |=> !o_wr.we && o_acc == ($past(o_acc) | $past(i_reg_rdata)))
        else $error("or register to acc wrong");
    AST_ORREG_REG: assert property (
        (i_valid && o_ready && i_instr.op == BOIME_OP_ORREG && i_instr.dest)
        |=> o_wr.we && o_wr.data == ($past(o_acc) | $past(i_reg_rdata))
        && $stable(o_acc))
        else $error("or register to register wrong");
    AST_MOVE_ACC: assert property (
        (i_valid && o_ready && i_instr.op == BOIME_OP_MOVE && !i_instr.dest)
        |=> !o_wr.we && o_acc == $past(i_reg_rdata)
        && o_zero == ($past(i_reg_rdata) == 8'h00))
        else $error("move to acc wrong");
    AST_MOVE_TEST: assert property (
        (i_valid && o_ready && i_instr.op == BOIME_OP_MOVE && i_instr.dest)
        |=> $stable(o_acc) && o_wr.we && o_wr.data == $past(i_reg_rdata)
        && o_zero == ($past(i_reg_rdata) == 8'h00))
        else $error("move test wrong");
    AST_ZERO: assert property (
        o_wr.we |-> o_zero == (o_wr.data == 8'h00))
        else $error("zero flag wrong");
    AST_ZERO_ACC: assert property (
        (i_valid && o_ready && (i_instr.op == BOIME_OP_ORLIT
        || (i_instr.op inside {BOIME_OP_INC, BOIME_OP_ORREG, BOIME_OP_MOVE}
        && !i_instr.dest))) |=> o_zero == (o_acc == 8'h00))
        else $error("zero flag after acc write wrong");
endmodule : boime_exec

// >>> boime_pkg.sv
// Package for the branch/or/increment/move execution unit
package boime_pkg;
    localparam int unsigned BOIME_DATA_W = 8;
    localparam int unsigned BOIME_PC_W = 13;
    localparam int unsigned BOIME_IMM_W = 11;
    localparam int unsigned BOIME_ADDR_W = 7;
    localparam int unsigned BOIME_LATCH_LO = 3;
    localparam int unsigned BOIME_LATCH_HI = 4;
    localparam logic [7:0] BOIME_ACC_RST = 8'h00;
    localparam logic [12:0] BOIME_PC_RST = 13'h0000;
    localparam logic [3:0] BOIME_JUMP_CYCLES = 4'h2;

    // Operation select
    typedef enum logic [2:0]
    {
        BOIME_OP_JUMP = 3'h0,
        BOIME_OP_ORLIT = 3'h1,
        BOIME_OP_INC = 3'h2,
        BOIME_OP_ORREG = 3'h3,
        BOIME_OP_MOVE = 3'h4
    } boime_op_type;

    // One instruction presented to the unit
    typedef struct packed
    {
        boime_op_type op;
        logic [10:0] imm;
        logic [6:0] addr;
        logic dest;
    } boime_instr_type;

    // Write to the data register file
    typedef struct packed
    {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } boime_wr_type;
endpackage : boime_pkg

// >>> tb_branch_or_incr_move_exec.sv
// Self-checking bench for the jump/or/increment/move execution unit
module tb_branch_or_incr_move_exec;
    timeunit 1ns;
    timeprecision 1ps;
    import boime_pkg::*;
    // One instruction beside the results it should leave
    typedef struct packed
    {
        logic [2:0] op;
        logic [10:0] imm;
        logic [6:0] addr;
        logic dest;
        logic [7:0] rd;
        logic [7:0] lat;
        logic [7:0] acc;
        logic z;
        logic we;
        logic [7:0] wd;
    } boime_row_type;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_valid = 1'b0;
    boime_instr_type i_instr = '0;
    logic [7:0] i_reg_rdata = 8'h00;
    logic [7:0] i_pc_high_latch = 8'h00;
    logic o_ready;
    logic [12:0] o_pc;
    logic [7:0] o_acc;
    logic o_zero;
    boime_wr_type o_wr;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    boime_row_type r;
    logic [12:0] exp_pc = 13'h0000;
    boime_row_type rows [13] = '{
        '{3'h1, 11'h000, 7'h00, 1'b0, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00},
        '{3'h1, 11'h581, 7'h00, 1'b0, 8'h00, 8'h00, 8'h81, 1'b0, 1'b0, 8'h00},
        '{3'h0, 11'h7ff, 7'h00, 1'b0, 8'h00, 8'he7, 8'h81, 1'b0, 1'b0, 8'h00},
        '{3'h2, 11'h000, 7'h05, 1'b1, 8'hff, 8'h00, 8'h81, 1'b1, 1'b1, 8'h00},
        '{3'h0, 11'h123, 7'h00, 1'b0, 8'h00, 8'h18, 8'h81, 1'b1, 1'b0, 8'h00},
        '{3'h2, 11'h000, 7'h0a, 1'b0, 8'h7f, 8'h00, 8'h80, 1'b0, 1'b0, 8'h00},
        '{3'h3, 11'h000, 7'h7f, 1'b1, 8'h03, 8'h00, 8'h80, 1'b0, 1'b1, 8'h83},
        '{3'h3, 11'h000, 7'h01, 1'b0, 8'h00, 8'h00, 8'h80, 1'b0, 1'b0, 8'h00},
        '{3'h4, 11'h000, 7'h02, 1'b0, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00},
        '{3'h4, 11'h000, 7'h11, 1'b1, 8'h5a, 8'h00, 8'h00, 1'b0, 1'b1, 8'h5a},
        '{3'h3, 11'h000, 7'h03, 1'b0, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00},
        '{3'h7, 11'h000, 7'h00, 1'b0, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00},
        '{3'h0, 11'h400, 7'h00, 1'b0, 8'h00, 8'h08, 8'h00, 1'b1, 1'b0, 8'h00}};

    boime_exec u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_valid(i_valid), .i_instr(i_instr), .i_reg_rdata(i_reg_rdata),
        .i_pc_high_latch(i_pc_high_latch), .o_ready(o_ready), .o_pc(o_pc),
        .o_acc(o_acc), .o_zero(o_zero), .o_wr(o_wr));

    // Free-running core clock
    initial
    begin
        forever #2 i_core_clk = ~i_core_clk;
    end

    // Compare one value, count it
    task chk(input string n, input logic [12:0] e, input logic [12:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // Offer one instruction, let the taking edge land
    task exec(input boime_row_type x);
        @(posedge i_core_clk);
        i_valid <= 1'b1;
        i_instr <= {x.op, x.imm, x.addr, x.dest};
        i_reg_rdata <= x.rd;
        i_pc_high_latch <= x.lat;
        @(posedge i_core_clk);
        i_valid <= 1'b0;
        #1;
    endtask : exec

    // Counts and verdict
    task report_and_stop();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    // Hang guard
    always @(posedge i_core_clk)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            err_total++;
            report_and_stop();
        end
    end

    // Main sequence
    initial
    begin
        repeat (16) @(posedge i_core_clk);
        i_rst <= 1'b0;
        #1;
        chk("pc", 13'h0000, o_pc);
        chk("ready", 1'b0, o_ready);
        for (int n = 0; n < 13; n++)
        begin
            r = rows[n];
            exp_pc = (r.op == 3'h0) ? {r.lat[4:3], r.imm} : exp_pc + 13'h1;
            exec(r);
            chk("acc", r.acc, o_acc);
            chk("zero", r.z, o_zero);
            chk("we", r.we, o_wr.we);
            if (r.we) chk("wdata", r.wd, o_wr.data);
            if (r.we) chk("waddr", r.addr, o_wr.addr);
            chk("pc", exp_pc, o_pc);
            if (r.op == 3'h0) chk("ready", 1'b0, o_ready);
        end
        // Instruction held into the bubble after a jump is dropped
        @(posedge i_core_clk);
        i_valid <= 1'b1;
        i_instr <= {3'h0, 11'h0ab, 7'h00, 1'b0};
        i_pc_high_latch <= 8'h10;
        @(posedge i_core_clk);
        i_instr <= {3'h1, 11'h0ff, 7'h00, 1'b0};
        @(posedge i_core_clk);
        i_valid <= 1'b0;
        #1;
        chk("acc", 13'h0000, o_acc);
        chk("zero", 1'b1, o_zero);
        chk("pc", 13'h10ab, o_pc);
        // Reset in mid-run clears state
        @(posedge i_core_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        #1;
        chk("pc", 13'h0000, o_pc);
        chk("zero", 1'b0, o_zero);
        chk("ready", 1'b0, o_ready);
        // Release again: nothing early, first instruction at the second edge
        @(posedge i_core_clk);
        i_rst <= 1'b0;
        #1;
        chk("ready", 1'b0, o_ready);
        r = '{3'h1, 11'h0c3, 7'h00, 1'b0, 8'h00, 8'h00, 8'hc3, 1'b0, 1'b0,
            8'h00};
        exec(r);
        chk("acc", r.acc, o_acc);
        chk("zero", r.z, o_zero);
        chk("pc", 13'h0001, o_pc);
        report_and_stop();
    end
endmodule : tb_branch_or_incr_move_exec
